/* rtl/startup_fault_sequencer.sv */
// startup, soft-start and fault latch sequencer for a step-up converter
// ****************************************************************
// How it works
// RQ1: startup begins once the synchronised input supply is above lockout.
// RQ2: input below lockout turns off converter, regulator, switch control, amplifier.
// RQ3: enable only with supply and rail above lockout and no fault latch.
// RQ4: after enable, open-loop switching builds the regulator supply first.
// RQ5: reference powers up only once the internal logic supply is high enough.
// RQ6: reference ready enables PWM and current limit and starts soft-start.
// RQ7: soft-start ramps current limit from zero in 128 equal steps.
// RQ8: soft-start ends at regulation or on timeout, whichever first.
// RQ9: in steady state a low feedback starts the fault timer.
// RQ10: unbroken feedback fault for the timer length sets the fault latch.
// RQ11: fault latch holds until the input supply is cycled.
// RQ12: feedback fault detection is held off during soft-start.
// RQ13: rail undervoltage or overvoltage blocks the gate driver.
// RQ14: rail limits only suspend switching, never set the fault latch.
// RQ15: thermal trip at once sets a latch that shuts everything down.
// RQ16: regulator_disable_n low turns off only the step-up converter.
// RQ17: the outside party cycles the input supply to clear thermal latch.
// RQ18: fault timer and soft-start timeout are cycle-count parameters.
// RQ19: every comparator input passes two flip-flops before use.
// ****************************************************************
module startup_fault_sequencer
  import startup_pkg::*;
#(
  parameter int unsigned SOFTSTART_CYCLES = SOFTSTART_CYC,
  parameter int unsigned FAULT_CYCLES = FAULT_CYC,
  parameter int unsigned STEP_CYCLES = SOFTSTART_CYC / ILIM_STEPS / 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // comparator levels from the analog side, asynchronous
  input wire logic supply_lockout_ok,
  input wire logic stepup_output_rail_ok,
  input wire logic stepup_output_rail_uv,
  input wire logic stepup_output_rail_ov,
  input wire logic feedback_sense_low,
  input wire logic internal_logic_supply_ok,
  input wire logic ref_ready,
  input wire logic output_in_regulation,
  input wire logic thermal_trip,
  input wire logic regulator_disable_n,
  // controls to the power stage
  output logic device_en,
  output logic converter_en,
  output logic openloop_en,
  output logic ref_en,
  output logic pwm_en,
  output logic gate_drive_en,
  output logic linreg_en,
  output logic switch_ctl_en,
  output logic amp_en,
  output logic [ILIM_W-1:0] ilim_code,
  // status
  output logic fault_latched,
  output logic thermal_latched,
  output logic softstart_active
);
  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  logic [SYNC_N-1:0] raw_a, sync_a;
  logic [2:0] raw_b, sync_b;
  logic [SYNC_N-1:0] sync_b_full;
  sense_s sn;
  logic vl_ok, in_reg, dis_n;

  assign raw_a = {supply_lockout_ok, stepup_output_rail_ok, stepup_output_rail_uv,
                  stepup_output_rail_ov, feedback_sense_low, ref_ready, thermal_trip};
  assign raw_b = {internal_logic_supply_ok, output_in_regulation, regulator_disable_n};

  // RQ19: comparator synchronisers
  sense_sync u_sync_a (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .raw(raw_a),
    .sync(sync_a)
  );

  sense_sync u_sync_b (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .raw({4'h0, raw_b}),
    .sync(sync_b_full)
  );
  // upper bits carry the tied-low padding and are not used
  assign sync_b = sync_b_full[2:0];

  assign sn = sync_a;
  assign vl_ok = sync_b[2];
  assign in_reg = sync_b[1];
  assign dis_n = sync_b[0];

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  seq_state_e st_r, st_nxt;
  logic fault_r, fault_nxt;
  logic therm_r, therm_nxt;
  logic [ILIM_W-1:0] ilim_r, ilim_nxt;
  logic [TMR_W-1:0] ss_cnt_r, ss_cnt_nxt;
  logic [TMR_W-1:0] step_cnt_r, step_cnt_nxt;
  ctl_s ctl_r, ctl_nxt;
  logic soft_r, soft_nxt;
  logic fb_expired;
  logic fb_watch;
  logic run_ok;

  // RQ9: timer only in steady state
  // RQ12: held off during soft-start
  assign fb_watch = (st_r == ST_RUN) && sn.fb_low;

  // RQ10: persistent feedback fault
  // RQ18: fault timer length as parameter
  fault_timer #(
    .LIMIT(TMR_W'(FAULT_CYCLES))
  ) u_fault_timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .run(fb_watch),
    .expired(fb_expired)
  );

  // RQ3: enable condition
  assign run_ok = sn.supply_ok && sn.rail_ok && !fault_r && !therm_r;

  always_comb begin
    st_nxt = st_r;
    fault_nxt = fault_r;
    therm_nxt = therm_r;
    ilim_nxt = ilim_r;
    ss_cnt_nxt = ss_cnt_r;
    step_cnt_nxt = step_cnt_r;
    // RQ11: latches hold until input supply drops
    if (!sn.supply_ok) begin
      fault_nxt = 1'b0;
      therm_nxt = 1'b0;
    end
    // RQ15: thermal latch set at once, set wins
    if (sn.therm_trip) begin
      therm_nxt = 1'b1;
    end
    // RQ10: set the fault latch
    // RQ14: rail limits never feed this latch
    if (fb_expired && st_r == ST_RUN) begin
      fault_nxt = 1'b1;
    end
    case (st_r)
      ST_OFF: begin
        ilim_nxt = ILIM_ZERO;
        // RQ1: start when supply is up
        if (run_ok) begin
          st_nxt = ST_BOOT;
        end
      end
      // RQ4: open-loop bootstrap
      ST_BOOT: begin
        // RQ5: reference waits for logic supply
        if (vl_ok) begin
          st_nxt = ST_REFUP;
        end
      end
      ST_REFUP: begin
        // RQ6: reference ready enters soft-start
        if (sn.ref_ready) begin
          st_nxt = ST_SOFT;
          ss_cnt_nxt = '0;
          step_cnt_nxt = '0;
          ilim_nxt = ILIM_ZERO;
        end
      end
      ST_SOFT: begin
        ss_cnt_nxt = ss_cnt_r + 24'h000001;
        // RQ7: one equal step at a time
        if (step_cnt_r >= TMR_W'(STEP_CYCLES) - 24'h000001) begin
          step_cnt_nxt = '0;
          if (ilim_r != ILIM_FULL) begin
            ilim_nxt = ilim_r + 8'h01;
          end
        end else begin
          step_cnt_nxt = step_cnt_r + 24'h000001;
        end
        // RQ8: regulation or timeout ends soft-start
        if (in_reg || ss_cnt_r >= TMR_W'(SOFTSTART_CYCLES) - 24'h000001) begin
          st_nxt = ST_RUN;
          ilim_nxt = ILIM_FULL;
        end
      end
      ST_RUN: begin
        ilim_nxt = ILIM_FULL;
      end
      ST_LATCHED: begin
        ilim_nxt = ILIM_ZERO;
        if (!sn.supply_ok) begin
          st_nxt = ST_OFF;
        end
      end
      default: begin
        st_nxt = ST_OFF;
      end
    endcase
    // RQ2: supply loss or latch shuts the sequence down
    if (fault_nxt || therm_nxt) begin
      st_nxt = ST_LATCHED;
      ilim_nxt = ILIM_ZERO;
    end else if (st_r != ST_OFF && st_r != ST_LATCHED && !run_ok) begin
      st_nxt = ST_OFF;
      ilim_nxt = ILIM_ZERO;
    end
  end

  // ****************************************************************
  // output enables
  // ****************************************************************
  logic active_nxt;
  logic latched_nxt;
  assign active_nxt = st_nxt inside {ST_BOOT, ST_REFUP, ST_SOFT, ST_RUN};
  assign latched_nxt = st_nxt == ST_LATCHED;

  always_comb begin
    ctl_nxt = '0;
    soft_nxt = (st_nxt == ST_SOFT);
    // RQ3: enable tracks sequence activity
    ctl_nxt.device_en = active_nxt;
    // RQ16: disable input stops only the converter
    ctl_nxt.converter_en = active_nxt && dis_n;
    ctl_nxt.openloop_en = (st_nxt == ST_BOOT || st_nxt == ST_REFUP) && dis_n;
    ctl_nxt.ref_en = st_nxt inside {ST_REFUP, ST_SOFT, ST_RUN};
    ctl_nxt.pwm_en = (st_nxt == ST_SOFT || st_nxt == ST_RUN) && dis_n;
    // RQ13: rail out of range blocks the gate driver
    ctl_nxt.gate_drive_en = active_nxt && dis_n && !sn.rail_uv && !sn.rail_ov;
    // RQ2: off on supply loss or latch
    ctl_nxt.linreg_en = active_nxt;
    ctl_nxt.switch_ctl_en = sn.supply_ok && !latched_nxt;
    ctl_nxt.amp_en = sn.supply_ok && !latched_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= ST_OFF;
      fault_r <= 1'b0;
      therm_r <= 1'b0;
      ilim_r <= ILIM_ZERO;
      ss_cnt_r <= '0;
      step_cnt_r <= '0;
      ctl_r <= '0;
      soft_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fault_r <= fault_nxt;
      therm_r <= therm_nxt;
      ilim_r <= ilim_nxt;
      ss_cnt_r <= ss_cnt_nxt;
      step_cnt_r <= step_cnt_nxt;
      ctl_r <= ctl_nxt;
      soft_r <= soft_nxt;
    end
  end

  assign device_en = ctl_r.device_en;
  assign converter_en = ctl_r.converter_en;
  assign openloop_en = ctl_r.openloop_en;
  assign ref_en = ctl_r.ref_en;
  assign pwm_en = ctl_r.pwm_en;
  assign gate_drive_en = ctl_r.gate_drive_en;
  assign linreg_en = ctl_r.linreg_en;
  assign switch_ctl_en = ctl_r.switch_ctl_en;
  assign amp_en = ctl_r.amp_en;
  assign ilim_code = ilim_r;
  assign fault_latched = fault_r;
  assign thermal_latched = therm_r;
  assign softstart_active = soft_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_enable_needs_ok: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ3
    device_en |-> $past(sn.supply_ok) && $past(sn.rail_ok) && !fault_r && !therm_r)
    else $error("enable without supply and rail ok");
  a_fault_off: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ10
    $rose(fault_r) |=> !device_en && !linreg_en && !amp_en && !switch_ctl_en)
    else $error("fault latch did not shut down");
  a_fault_holds: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ11
    fault_r && sn.supply_ok |=> fault_r)
    else $error("fault latch cleared with supply up");
  a_soft_no_fault: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ12
    st_r == ST_SOFT |=> !fb_expired && !fault_r)
    else $error("fault timer ran in soft-start");
  a_gate_blocked: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ13
    sn.rail_ov || sn.rail_uv |=> !gate_drive_en)
    else $error("gate driver on with rail out of range");
  a_therm_latch: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ15
    sn.therm_trip |=> therm_r ##1 !device_en && !amp_en)
    else $error("thermal trip not latched");
  a_ilim_step: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ7
    st_r == ST_SOFT && $past(st_r) == ST_SOFT |-> ilim_r - $past(ilim_r) <= 8'h01)
    else $error("current limit stepped more than one");
  a_soft_end: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ8
    st_r == ST_SOFT && in_reg && !fault_nxt && !therm_nxt && run_ok |=> st_r == ST_RUN)
    else $error("soft-start did not end at regulation");
  a_supply_drop: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ2
    !sn.supply_ok |=> !converter_en && !linreg_en && !amp_en)
    else $error("supply loss did not shut down");
  a_disable_conv: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ16
    !dis_n |=> !converter_en && !pwm_en)
    else $error("converter on while disabled");
endmodule

/* rtl/startup_pkg.sv */
// package: states, timing constants and carriers for the startup and fault sequencer
package startup_pkg;
  // clock is 200 MHz
  localparam int unsigned CLK_MHZ = 200;
  // soft-start timeout in microseconds
  localparam int unsigned SOFTSTART_US = 3000;
  localparam int unsigned SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ;
  // fault timer length in microseconds (not documented, plain default)
  localparam int unsigned FAULT_US = 100;
  localparam int unsigned FAULT_CYC = FAULT_US * CLK_MHZ;
  // current limit ramp: 128 equal steps
  localparam int unsigned ILIM_STEPS = 128;
  localparam int unsigned ILIM_W = 8;
  localparam logic [ILIM_W-1:0] ILIM_FULL = 8'h80;
  localparam logic [ILIM_W-1:0] ILIM_ZERO = 8'h00;
  localparam int unsigned TMR_W = 24;
  localparam int unsigned SYNC_N = 7;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_BOOT    = 3'b001,
    ST_REFUP   = 3'b010,
    ST_SOFT    = 3'b011,
    ST_RUN     = 3'b100,
    ST_LATCHED = 3'b101
  } seq_state_e;

  // synchronised comparator levels
  typedef struct packed {
    logic supply_ok;
    logic rail_ok;
    logic rail_uv;
    logic rail_ov;
    logic fb_low;
    logic ref_ready;
    logic therm_trip;
  } sense_s;

  // enables sent to the analog power stage
  typedef struct packed {
    logic device_en;
    logic converter_en;
    logic openloop_en;
    logic ref_en;
    logic pwm_en;
    logic gate_drive_en;
    logic linreg_en;
    logic switch_ctl_en;
    logic amp_en;
  } ctl_s;
endpackage

/* rtl/sense_sync.sv */
// two-flop synchroniser for a bundle of comparator levels
module sense_sync
  import startup_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // raw and synchronised levels
  input wire logic [SYNC_N-1:0] raw,
  output logic [SYNC_N-1:0] sync
);
  logic [SYNC_N-1:0] meta_r, meta_nxt;
  logic [SYNC_N-1:0] sync_r, sync_nxt;

  // RQ19: two flops per input
  always_comb begin
    meta_nxt = raw;
    sync_nxt = meta_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync = sync_r;
endmodule

/* rtl/fault_timer.sv */
// counter that fires after a level has stood unbroken for a set number of cycles
module fault_timer
  import startup_pkg::*;
#(
  parameter logic [TMR_W-1:0] LIMIT = 24'h000100
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // condition and expiry
  input wire logic run,
  output logic expired
);
  logic [TMR_W-1:0] cnt_r, cnt_nxt;
  logic exp_r, exp_nxt;

  // any break in the condition restarts the count
  always_comb begin
    cnt_nxt = '0;
    exp_nxt = 1'b0;
    if (run) begin
      if (cnt_r >= LIMIT - 24'h000001) begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 24'h000001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired = exp_r;
endmodule

/* verif/analog_stage.sv */
// behavioural model of the analog power stage, its comparators and thermal sensor
module analog_stage
  import startup_pkg::*;
#(
  parameter int unsigned LAG = 8
) (
  // clock
  input wire logic ref_clk,
  // conditions imposed by the bench
  input wire logic supply_on,
  input wire logic rail_dn,
  input wire logic uv_f,
  input wire logic ov_f,
  input wire logic hold_reg,
  input wire logic fb_fault,
  input wire logic hot,
  // enables from the sequencer
  input wire ctl_s ctl,
  // comparator levels
  output sense_s sense,
  output logic logic_ok,
  output logic in_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // supplies and regulation
  // ****************************************************************
  int unsigned vl_n = 0;
  int unsigned ref_n = 0;
  int unsigned reg_n = 0;
  // logic supply only builds while open-loop switching feeds the regulator
  always @(negedge ref_clk) begin
    vl_n <= (supply_on && ctl.openloop_en && ctl.linreg_en) ? vl_n + 1 : 0;
    ref_n <= (logic_ok && ctl.ref_en) ? ref_n + 1 : 0;
    reg_n <= (ctl.pwm_en && !hold_reg) ? reg_n + 1 : 0;
  end
  assign logic_ok = vl_n >= LAG;
  assign in_reg = reg_n >= 4 * LAG;
  assign sense.supply_ok = supply_on;
  assign sense.rail_ok = supply_on && !rail_dn;
  assign sense.rail_uv = uv_f;
  assign sense.rail_ov = ov_f;
  // feedback stays low until the output regulates, so soft-start sees it low
  assign sense.fb_low = !in_reg || fb_fault;
  assign sense.ref_ready = ref_n >= LAG;
  assign sense.therm_trip = hot;
endmodule

/* verif/tb_top.sv */
// self-checking bench for the startup and fault sequencer
module tb_top
  import startup_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // short counts keep the run small
  localparam int SS = 2000;
  localparam int FC = 50;
  localparam int ST = 4;
  logic ref_clk, resetn, supply_on, rail_dn, uv_f, ov_f, hold_reg, fb_fault, hot, reg_dis_n;
  sense_s sense;
  logic logic_ok, in_reg;
  logic device_en, converter_en, openloop_en, ref_en, pwm_en, gate_drive_en;
  logic linreg_en, switch_ctl_en, amp_en, fault_latched, thermal_latched, softstart_active;
  logic [7:0] ilim_code;
  logic [7:0] p;
  ctl_s ctl;
  logic [11:0] o;
  int fail_count = 0;
  int n_compared = 0;
  int n, m;
  assign ctl = {device_en, converter_en, openloop_en, ref_en, pwm_en, gate_drive_en,
                linreg_en, switch_ctl_en, amp_en};
  assign o = {ctl, fault_latched, thermal_latched, softstart_active};

  startup_fault_sequencer #(.SOFTSTART_CYCLES(SS), .FAULT_CYCLES(FC), .STEP_CYCLES(ST))
  u_startup_fault_sequencer (.ref_clk(ref_clk), .resetn(resetn),
    .supply_lockout_ok(sense.supply_ok), .stepup_output_rail_ok(sense.rail_ok),
    .stepup_output_rail_uv(sense.rail_uv), .stepup_output_rail_ov(sense.rail_ov),
    .feedback_sense_low(sense.fb_low), .internal_logic_supply_ok(logic_ok),
    .ref_ready(sense.ref_ready), .output_in_regulation(in_reg),
    .thermal_trip(sense.therm_trip), .regulator_disable_n(reg_dis_n),
    .device_en(device_en), .converter_en(converter_en), .openloop_en(openloop_en),
    .ref_en(ref_en), .pwm_en(pwm_en), .gate_drive_en(gate_drive_en), .linreg_en(linreg_en),
    .switch_ctl_en(switch_ctl_en), .amp_en(amp_en), .ilim_code(ilim_code),
    .fault_latched(fault_latched), .thermal_latched(thermal_latched),
    .softstart_active(softstart_active));

  analog_stage u_analog_stage (.ref_clk(ref_clk), .supply_on(supply_on), .rail_dn(rail_dn),
    .uv_f(uv_f), .ov_f(ov_f), .hold_reg(hold_reg), .fb_fault(fb_fault), .hot(hot),
    .ctl(ctl), .sense(sense), .logic_ok(logic_ok), .in_reg(in_reg));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for one observed output; n holds the cycles it took
  task wt(input int i, input logic v, input int lim);
    n = 0;
    while (o[i] !== v) begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        fail_count++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, o[i], v);
        results();
      end
    end
  endtask

  task cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task up();
    wt(11, 1'h1, 20); // starts on supply
    chk(openloop_en, 1'h1); // open loop first
    chk({ref_en, pwm_en}, 2'h0); // reference waits
    wt(8, 1'h1, 40); // reference follows logic supply
    wt(7, 1'h1, 40); // pwm on ready
    chk({softstart_active, ilim_code}, 9'h100); // ramp from zero
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {resetn, supply_on, uv_f, ov_f, fb_fault, hot} = 6'h0;
    {rail_dn, hold_reg, reg_dis_n} = 3'h7;
    cyc(6);
    chk({o, ilim_code}, 20'h0); // quiet in reset
    resetn = 1'h1;
    supply_on = 1'h1;
    cyc(20);
    chk(device_en, 1'h0); // rail gates enable
    rail_dn = 1'h0;
    up();
    // regulation withheld: full ramp, then timeout with feedback low throughout
    p = 8'h0;
    n = 0;
    while (ilim_code !== 8'h80 && n < 1000) begin
      @(negedge ref_clk);
      n++;
      if (ilim_code !== p) begin
        chk(ilim_code, p + 8'h1); // single steps
        p = ilim_code;
      end
    end
    chk(n >= 128 * ST - 4 && n <= 128 * ST + 4, 1'h1); // ramp spans 128 steps of ST cycles
    m = n;
    wt(0, 1'h0, SS); // timeout ends soft-start
    chk(m + n >= SS - 6 && m + n <= SS + 6, 1'h1); // timeout at SS cycles from ramp start
    chk(fault_latched, 1'h0); // held off in ramp
    wt(2, 1'h1, FC + 10); // timer runs on low feedback
    chk(n >= FC - 4, 1'h1); // full duration
    chk(o[11:3], 9'h0); // all shut down
    hold_reg = 1'h0;
    cyc(20);
    chk(fault_latched, 1'h1); // latch holds
    supply_on = 1'h0;
    wt(2, 1'h0, 10); // supply cycle clears
    chk(o[11:3], 9'h0); // off below lockout
    supply_on = 1'h1;
    up();
    wt(0, 1'h0, SS); // regulation ends soft-start
    chk({n < SS / 2, ilim_code}, 9'h180); // regulation ends ramp
    repeat (4) begin
      fb_fault = 1'h1;
      cyc(FC - 10);
      fb_fault = 1'h0;
      cyc(5);
    end
    chk(fault_latched, 1'h0); // broken fault ignored
    for (int i = 0; i < 2; i++) begin
      {ov_f, uv_f} = i ? 2'h2 : 2'h1;
      wt(6, 1'h0, 8); // rail limit stops gate
      cyc(FC * 2);
      chk(fault_latched, 1'h0); // no latch from rail
      {ov_f, uv_f} = 2'h0;
      wt(6, 1'h1, 8); // gate resumes
    end
    reg_dis_n = 1'h0;
    wt(10, 1'h0, 8); // converter off
    chk({switch_ctl_en, amp_en, linreg_en}, 3'h7); // rest stays on
    reg_dis_n = 1'h1;
    wt(10, 1'h1, 20); // converter back
    hot = 1'h1;
    wt(1, 1'h1, 8); // immediate latch
    chk(o[11:3], 9'h0); // all shut down
    hot = 1'h0;
    cyc(20);
    chk(thermal_latched, 1'h1); // stays after cooling
    supply_on = 1'h0;
    wt(1, 1'h0, 10); // supply cycle clears
    supply_on = 1'h1;
    up();
    wt(0, 1'h0, SS); // restart reaches steady state
    supply_on = 1'h0;
    wt(10, 1'h0, 8); // converter off on loss
    chk({linreg_en, switch_ctl_en, amp_en}, 3'h0); // rest off too
    results();
  end
endmodule
